/* File: src/emw_ctrl.sv */
// external memory window control with AHB-Lite register slave
//
// Function
// - page map bits appended on page window access
// - page register supplies page address 28..13
// - pins 8..0 carry page bits 21..13
// - sram mode uses only pins 4..0
// - page chip select asserted in page space
// - upper enable gives pin 15 addressing, pins 18..16 low
// - pins 18..15 high after reset, disabled
// - ram merge adds ram select to page
// - rom merge adds rom select to page
// - bit 11 sets page region width
// - bits 10..8 set page wait states
// - bit 7 sets rom width
// - bits 6..4 set rom wait states
// - bit 3 sets ram width
// - bits 2..0 set ram wait states
// - wait states counted in system clocks
// - two page registers at separate addresses
`timescale 1ns/1ps
`include "emw_consts.svh"
module emw_ctrl
  import emw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cpu_req,
  input wire emw_cpu_req_t cpu_cmd,
  output logic cpu_ack,
  output logic [15:0] cpu_rdata,
  input wire logic [15:0] ext_data_in,
  output emw_ext_out_t ext_out
);

  logic [15:0] page1;
  logic [15:0] page2;
  logic [15:0] hi_en_reg;
  logic [15:0] ctrl;
  logic [15:0] mode;
  logic ap_valid;
  logic wr_pend;
  logic [17:0] wr_addr;
  logic [15:0] rd_mux;
  logic addr_hi_zero;
  emw_state_t state;
  emw_cpu_req_t req_q;
  emw_region_t dec_region;
  emw_region_t region_q;
  logic dec_byte;
  logic [2:0] dec_wait;
  logic [15:0] dec_page;
  logic byte_q;
  logic [2:0] wait_q;
  logic [15:0] page_q;
  logic byte_sel;
  logic ctr_load;
  logic ctr_done;
  logic strobe;
  logic is_page;
  logic dec_external;
  logic [3:0] hi_pins;
  logic [8:0] page_pins;

  // bus slave: always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_valid = hsel && htrans[1] && hready;
  assign addr_hi_zero = (haddr[31:18] == 14'h0000);

  always_comb begin
    rd_mux = 16'h0000;
    if (addr_hi_zero) begin
      unique case (haddr[17:0])
        `EMW_ADDR_PAGE1: rd_mux = page1;
        `EMW_ADDR_PAGE2: rd_mux = page2;
        `EMW_ADDR_HI_EN: rd_mux = hi_en_reg;
        `EMW_ADDR_CTRL: rd_mux = ctrl;
        `EMW_ADDR_MODE: begin
          rd_mux = mode;
          rd_mux[`EMW_BUSY_BIT] = (state != EMW_IDLE);
        end
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  // read data taken in the address phase, shown in the data phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 18'h00000;
    end else begin
      wr_pend <= ap_valid && hwrite && addr_hi_zero;
      wr_addr <= haddr[17:0];
    end
  end

  // reserved bits masked so they read zero, except mode bit 8, which reads the busy flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      page1 <= `EMW_RST_PAGE;
      page2 <= `EMW_RST_PAGE;
      hi_en_reg <= `EMW_RST_HI_EN;
      ctrl <= `EMW_RST_CTRL;
      mode <= `EMW_RST_MODE;
    end else if (wr_pend) begin
      unique case (wr_addr)
        `EMW_ADDR_PAGE1: page1 <= hwdata[15:0] & `EMW_MASK_PAGE;
        `EMW_ADDR_PAGE2: page2 <= hwdata[15:0] & `EMW_MASK_PAGE;
        `EMW_ADDR_HI_EN: hi_en_reg <= hwdata[15:0] & `EMW_MASK_HI_EN;
        `EMW_ADDR_CTRL: ctrl <= hwdata[15:0] & `EMW_MASK_CTRL;
        `EMW_ADDR_MODE: mode <= hwdata[15:0] & `EMW_MASK_MODE;
        default: ;
      endcase
    end
  end

  emw_region_dec u_dec (
    .addr(cpu_cmd.addr),
    .ctrl(ctrl),
    .page1(page1),
    .page2(page2),
    .region(dec_region),
    .byte_width(dec_byte),
    .wait_cnt(dec_wait),
    .page_bits(dec_page)
  );

  // a page set to the internal half (bit 21) starts no external strobe
  always_comb begin
    dec_external = (dec_region != EMW_NONE);
    if ((dec_region == EMW_PAGE1) || (dec_region == EMW_PAGE2)) begin
      dec_external = !dec_page[`EMW_PAGE_INT_BIT];
    end
  end

  // counter runs on mclk, so waits are whole mclk periods
  emw_wait_ctr #(
    .WIDTH(3)
  ) u_wait (
    .mclk(mclk),
    .rst(rst),
    .load(ctr_load),
    .load_val(wait_q),
    .done(ctr_done)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= EMW_IDLE;
      byte_sel <= 1'b0;
    end else begin
      unique case (state)
        EMW_IDLE: begin
          if (cpu_req) begin
            state <= dec_external ? EMW_STROBE : EMW_DONE;
            byte_sel <= 1'b0;
          end
        end
        EMW_STROBE: begin
          if (strobe && ctr_done) begin
            if (byte_q && !byte_sel) begin
              state <= EMW_GAP;
              byte_sel <= 1'b1;
            end else begin
              state <= EMW_DONE;
            end
          end
        end
        EMW_GAP: state <= EMW_STROBE;
        EMW_DONE: state <= EMW_IDLE;
      endcase
    end
  end

  // counter loaded one cycle before each strobe begins
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctr_load <= 1'b0;
    end else begin
      ctr_load <= ((state == EMW_IDLE) && cpu_req && dec_external)
        || (strobe && ctr_done && byte_q && !byte_sel);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_q <= '0;
      region_q <= EMW_NONE;
      byte_q <= 1'b0;
      wait_q <= 3'h0;
      page_q <= 16'h0000;
    end else if ((state == EMW_IDLE) && cpu_req) begin
      req_q <= cpu_cmd;
      region_q <= dec_region;
      byte_q <= dec_byte;
      wait_q <= dec_wait;
      page_q <= dec_page;
    end
  end

  // internal page targets read back as zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_rdata <= 16'h0000;
    end else if ((state == EMW_IDLE) && cpu_req) begin
      cpu_rdata <= 16'h0000;
    end else if (strobe && ctr_done && !req_q.we) begin
      if (!byte_q) begin
        cpu_rdata <= ext_data_in;
      end else if (!byte_sel) begin
        cpu_rdata[7:0] <= ext_data_in[7:0];
      end else begin
        cpu_rdata[15:8] <= ext_data_in[7:0];
      end
    end
  end

  assign cpu_ack = (state == EMW_DONE);

  // strobe waits one cycle so the counter is loaded first
  assign strobe = (state == EMW_STROBE) && !ctr_load;
  assign is_page = (region_q == EMW_PAGE1) || (region_q == EMW_PAGE2);

  // sram mode drives pins 8..5 low, page bits on pins 4..0 only
  always_comb begin
    if (mode[`EMW_SRAM_MODE_BIT]) begin
      page_pins = {4'h0, page_q[4:0]};
    end else begin
      page_pins = page_q[8:0];
    end
  end

  always_comb begin
    if (hi_en_reg[`EMW_HI_EN_BIT]) begin
      hi_pins = {3'h0, req_q.addr[15]};
    end else begin
      hi_pins = `EMW_HI_IDLE;
    end
  end

  always_comb begin
    ext_out = '0;
    ext_out.addr[18:15] = hi_pins;
    ext_out.addr[14:1] = req_q.addr[14:1];
    ext_out.addr[0] = byte_q ? byte_sel : req_q.addr[0];
    ext_out.page_addr = is_page ? page_pins : 9'h000;
    if (byte_q && byte_sel) begin
      ext_out.wdata = {8'h00, req_q.wdata[15:8]};
    end else if (byte_q) begin
      ext_out.wdata = {8'h00, req_q.wdata[7:0]};
    end else begin
      ext_out.wdata = req_q.wdata;
    end
    ext_out.data_oe = strobe && req_q.we;
    ext_out.rd_n = !(strobe && !req_q.we);
    ext_out.wr_n = !(strobe && req_q.we);
    ext_out.ext_page_chip_select_n = !(strobe && is_page);
    ext_out.ext_ram_chip_select_n = !(strobe && ((region_q == EMW_RAM)
      || (is_page && ctrl[`EMW_RAM_MERGE_BIT])));
    ext_out.ext_rom_chip_select_n = !(strobe && ((region_q == EMW_ROM)
      || (is_page && ctrl[`EMW_ROM_MERGE_BIT])));
  end

  // helper: cycles the strobe has been low so far
  logic [3:0] strobe_len;
  always_ff @(posedge mclk) begin
    if (rst) begin
      strobe_len <= 4'h0;
    end else if (strobe) begin
      strobe_len <= strobe_len + 4'h1;
    end else begin
      strobe_len <= 4'h0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_page_bits_out:
    assert property (!ext_out.ext_page_chip_select_n
      && !mode[`EMW_SRAM_MODE_BIT] |-> ext_out.page_addr == page_q[8:0])
    else $error("page pins differ from page map bits");

  a_page_reg_source:
    assert property ((state == EMW_IDLE) && cpu_req
      && (cpu_cmd.addr[15:13] == `EMW_WIN_PAGE2)
      |=> page_q == $past(page2))
    else $error("page window did not latch its own map register");

  a_sram_mode_pins:
    assert property (!ext_out.ext_page_chip_select_n
      && mode[`EMW_SRAM_MODE_BIT] |-> ext_out.page_addr[8:5] == 4'h0
      && ext_out.page_addr[4:0] == page_q[4:0])
    else $error("sram mode page pins wrong");

  a_page_cs_region:
    assert property ((state == EMW_STROBE) && !ctr_load && is_page
      |-> !ext_out.ext_page_chip_select_n && $past(state) != EMW_IDLE)
    else $error("page chip select missing during page strobe");

  a_hi_pins_off:
    assert property (!hi_en_reg[`EMW_HI_EN_BIT]
      |-> ext_out.addr[18:15] == `EMW_HI_IDLE)
    else $error("upper pins not high while disabled");

  a_hi_pins_on:
    assert property (hi_en_reg[`EMW_HI_EN_BIT]
      |-> ext_out.addr[18:15] == {3'h0, req_q.addr[15]})
    else $error("upper pins not carrying address");

  a_ram_merge_cs:
    assert property (ctrl[`EMW_RAM_MERGE_BIT]
      && !ext_out.ext_page_chip_select_n |-> !ext_out.ext_ram_chip_select_n)
    else $error("ram select not merged");

  a_rom_merge_cs:
    assert property (!ctrl[`EMW_ROM_MERGE_BIT] && is_page
      |-> ext_out.ext_rom_chip_select_n)
    else $error("rom select asserted without merge");

  a_strobe_wait_len:
    assert property (strobe && ctr_done |-> strobe_len == {1'b0, wait_q})
    else $error("strobe length differs from wait count");

  a_byte_second_half:
    assert property (strobe && byte_q && ctr_done && !byte_sel
      |=> !strobe ##1 strobe && ext_out.addr[0])
    else $error("second byte access missing or wrong address");

  a_page_reg_write:
    assert property (wr_pend && (wr_addr == `EMW_ADDR_PAGE2)
      |=> page2 == $past(hwdata[15:0]) && $stable(page1))
    else $error("page two write failed");

  a_ack_single:
    assert property (cpu_ack |=> !cpu_ack && state == EMW_IDLE)
    else $error("acknowledge longer than one cycle");

endmodule // emw_ctrl

/* File: common/emw_consts.svh */
// constants for the external memory window control block
`ifndef EMW_CONSTS_SVH
`define EMW_CONSTS_SVH

// register indices; byte address is four times the index
`define EMW_IDX_PAGE1 16'hC018
`define EMW_IDX_PAGE2 16'hC01A
`define EMW_IDX_HI_EN 16'hC038
`define EMW_IDX_CTRL 16'hC03A
`define EMW_IDX_MODE 16'h0000
`define EMW_ADDR_PAGE1 ({`EMW_IDX_PAGE1, 2'b00})
`define EMW_ADDR_PAGE2 ({`EMW_IDX_PAGE2, 2'b00})
`define EMW_ADDR_HI_EN ({`EMW_IDX_HI_EN, 2'b00})
`define EMW_ADDR_CTRL ({`EMW_IDX_CTRL, 2'b00})
`define EMW_ADDR_MODE ({`EMW_IDX_MODE, 2'b00})

// reset values
`define EMW_RST_PAGE 16'h0000
`define EMW_RST_HI_EN 16'h0000
`define EMW_RST_CTRL 16'h0000
`define EMW_RST_MODE 16'h0000

// writable masks, reserved bits stay zero
`define EMW_MASK_PAGE 16'hFFFF
`define EMW_MASK_HI_EN 16'h0008
`define EMW_MASK_CTRL 16'h3FFF
`define EMW_MASK_MODE 16'h0001

// field positions
`define EMW_HI_EN_BIT 3
`define EMW_RAM_MERGE_BIT 13
`define EMW_ROM_MERGE_BIT 12
`define EMW_PAGE_WIDTH_BIT 11
`define EMW_PAGE_WAIT_LSB 8
`define EMW_ROM_WIDTH_BIT 7
`define EMW_ROM_WAIT_LSB 4
`define EMW_RAM_WIDTH_BIT 3
`define EMW_RAM_WAIT_LSB 0
`define EMW_SRAM_MODE_BIT 0
`define EMW_BUSY_BIT 8
`define EMW_PAGE_INT_BIT 8

// processor address windows, decoded on the top bits
`define EMW_WIN_PAGE1 3'h4
`define EMW_WIN_PAGE2 3'h5
`define EMW_WIN_ROM 3'h7
`define EMW_WIN_RAM 2'h1

// pins A18..A15 while the upper address is disabled
`define EMW_HI_IDLE 4'hF

`endif

/* File: common/emw_pkg.sv */
// types shared by the external memory window control block
package emw_pkg;

  typedef enum {
    EMW_NONE,
    EMW_PAGE1,
    EMW_PAGE2,
    EMW_RAM,
    EMW_ROM
  } emw_region_t;

  typedef enum {
    EMW_IDLE,
    EMW_STROBE,
    EMW_GAP,
    EMW_DONE
  } emw_state_t;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } emw_cpu_req_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [8:0] page_addr;
    logic [15:0] wdata;
    logic data_oe;
    logic rd_n;
    logic wr_n;
    logic ext_page_chip_select_n;
    logic ext_ram_chip_select_n;
    logic ext_rom_chip_select_n;
  } emw_ext_out_t;

endpackage

/* File: src/emw_wait_ctr.sv */
// down counter holding the strobe for the programmed wait states
`timescale 1ns/1ps
module emw_wait_ctr #(
  parameter int WIDTH = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);

  logic [WIDTH-1:0] cnt;

  // one count per system clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign done = (cnt == '0);

endmodule // emw_wait_ctr

/* File: src/emw_region_dec.sv */
// processor address decode into external regions and their timing
`timescale 1ns/1ps
`include "emw_consts.svh"
module emw_region_dec
  import emw_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic [15:0] ctrl,
  input wire logic [15:0] page1,
  input wire logic [15:0] page2,
  output emw_region_t region,
  output logic byte_width,
  output logic [2:0] wait_cnt,
  output logic [15:0] page_bits
);

  always_comb begin
    region = EMW_NONE;
    byte_width = 1'b0;
    wait_cnt = 3'h0;
    page_bits = 16'h0000;
    if (addr[15:13] == `EMW_WIN_PAGE1) begin
      region = EMW_PAGE1;
      page_bits = page1;
    end else if (addr[15:13] == `EMW_WIN_PAGE2) begin
      region = EMW_PAGE2;
      page_bits = page2;
    end else if (addr[15:13] == `EMW_WIN_ROM) begin
      region = EMW_ROM;
    end else if (addr[15:14] == `EMW_WIN_RAM) begin
      region = EMW_RAM;
    end
    unique case (region)
      EMW_PAGE1, EMW_PAGE2: begin
        byte_width = ctrl[`EMW_PAGE_WIDTH_BIT];
        wait_cnt = ctrl[`EMW_PAGE_WAIT_LSB +: 3];
      end
      EMW_ROM: begin
        byte_width = ctrl[`EMW_ROM_WIDTH_BIT];
        wait_cnt = ctrl[`EMW_ROM_WAIT_LSB +: 3];
      end
      EMW_RAM: begin
        byte_width = ctrl[`EMW_RAM_WIDTH_BIT];
        wait_cnt = ctrl[`EMW_RAM_WAIT_LSB +: 3];
      end
      EMW_NONE: begin
        byte_width = 1'b0;
      end
    endcase
  end

endmodule // emw_region_dec

/* File: bench/emw_ext_mem.sv */
// behavioural external memory answering the window controller
`timescale 1ns/1ps
module emw_ext_mem
  import emw_pkg::*;
(
  input wire logic mclk,
  input wire emw_ext_out_t ext_out,
  output logic [15:0] ext_data_in
);
  logic [15:0] last;
  logic sel;

  // fixed pattern so the bench can predict every byte
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  assign sel = !ext_out.ext_page_chip_select_n ||
               !ext_out.ext_ram_chip_select_n ||
               !ext_out.ext_rom_chip_select_n;

  // released bus shows the inverse of the last value, never a held copy
  always_comb begin
    if (sel && !ext_out.rd_n) begin
      ext_data_in = {pat({ext_out.addr[7:1], 1'b1}), pat(ext_out.addr[7:0])};
    end else begin
      ext_data_in = ~last;
    end
  end

  always_ff @(posedge mclk) begin
    last <= ext_data_in;
  end
endmodule // emw_ext_mem

/* File: bench/emw_ctrl_bench.sv */
// self-checking bench for the external memory window controller
`timescale 1ns/1ps
`include "emw_consts.svh"
module emw_ctrl_bench
  import emw_pkg::*;
;
  logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, cpu_req, cpu_ack;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] cpu_rdata, ext_data_in, ctrl, pg1, pg2;
  logic hien, sram;
  emw_cpu_req_t cpu_cmd;
  emw_ext_out_t ext_out;
  int checks, mismatches, seed, it, k;
  logic [31:0] ad [6];

  assign hready = hreadyout;

  emw_ctrl i_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_req(cpu_req), .cpu_cmd(cpu_cmd),
    .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
    .ext_data_in(ext_data_in), .ext_out(ext_out));

  emw_ext_mem i_mem (.mclk(mclk), .ext_out(ext_out),
    .ext_data_in(ext_data_in));

  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // single AHB-Lite transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    n = 0;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    n = 0;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 50);
    q = hrdata;
  endtask

  // one processor access into region r: 0 ram, 1 page1, 2 page2, 3 rom
  task automatic acc(input int r);
    logic [15:0] a, wd, pg;
    logic we, bw, pgr, pgin, prev, stb;
    logic [2:0] n;
    int c, lo, pul, ep;
    a = (r == 0) ? 16'h4000 : (r == 1) ? 16'h8000 :
        (r == 2) ? 16'hA000 : 16'hE000;
    a = a | (16'($random(seed)) & 16'h1FFE);
    we = $random(seed);
    wd = $random(seed);
    pgr = (r == 1 || r == 2);
    pg = (r == 2) ? pg2 : pg1;
    n = (r == 0) ? ctrl[2:0] : (r == 3) ? ctrl[6:4] : ctrl[10:8];
    bw = (r == 0) ? ctrl[3] : (r == 3) ? ctrl[7] : ctrl[11];
    pgin = pgr && pg[8];
    ep = pgin ? 0 : (bw ? 2 : 1);
    cpu_cmd <= '{we: we, addr: a, wdata: wd};
    cpu_req <= 1'b1;
    lo = 0;
    pul = 0;
    prev = 1'b0;
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
      stb = !ext_out.rd_n || !ext_out.wr_n;
      if (stb && !prev) begin
        chk("byte_sel", ext_out.addr[0], bw ? pul[0] : a[0]);
        if (we) chk("wdata", ext_out.wdata, !bw ? wd :
                    {8'h00, (pul == 1) ? wd[15:8] : wd[7:0]});
        chk("dir", {ext_out.data_oe, ext_out.wr_n, ext_out.rd_n},
            we ? 3'b101 : 3'b010);
        chk("selects", {ext_out.ext_page_chip_select_n,
            ext_out.ext_ram_chip_select_n, ext_out.ext_rom_chip_select_n},
            pgr ? {1'b0, ~ctrl[13], ~ctrl[12]} :
            (r == 0) ? 3'h5 : 3'h6);
        chk("page_pins", ext_out.page_addr, !pgr ? 9'h000 :
            sram ? {4'h0, pg[4:0]} : pg[8:0]);
        chk("upper_pins", ext_out.addr[18:15],
            hien ? {3'b000, a[15]} : 4'hF);
        pul++;
      end
      if (stb) lo++;
      prev = stb;
    end while (cpu_ack !== 1'b1 && c < 100);
    chk("acked", cpu_ack, 1'b1);
    if (!we) chk("rdata", cpu_rdata, pgin ? 16'h0000 :
        {pat({a[7:1], 1'b1}), pat({a[7:1], 1'b0})});
    chk("pulses", pul, ep);
    chk("strobe_len", lo, ep * (n + 1));
    cpu_req <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // limit well above the longest expected run
  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    end_of_test;
  end

  initial begin
    seed = 32'h4abd;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    cpu_req = 1'b0;
    cpu_cmd = '0;
    ad = '{`EMW_ADDR_PAGE1, `EMW_ADDR_PAGE2, `EMW_ADDR_HI_EN,
           `EMW_ADDR_CTRL, `EMW_ADDR_MODE, 32'h0003_0004};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("upper_rst", ext_out.addr[18:15], 4'hF);
    chk("sel_rst", {ext_out.ext_page_chip_select_n,
        ext_out.ext_ram_chip_select_n,
        ext_out.ext_rom_chip_select_n}, 3'h7);
    for (k = 0; k < 6; k++) begin
      bus(1'b0, ad[k], 32'h0, r);
      chk("reset_value", r, 32'h0);
      chk("hresp", hresp, 1'b0);
    end
    for (it = 0; it < 24; it++) begin
      ctrl = 16'($random(seed)) & `EMW_MASK_CTRL;
      if (it == 0) ctrl = 16'h0000;
      if (it == 1) ctrl = 16'h3FFF;
      hien = $random(seed);
      sram = $random(seed);
      pg1 = 16'($random(seed)) & 16'hFEFF;
      pg2 = 16'($random(seed)) & 16'hFEFF;
      // occasional internal page to see no external cycle happen
      if (it % 6 == 5) pg2[8] = 1'b1;
      bus(1'b1, ad[3], {16'h0, ctrl}, r);
      bus(1'b1, ad[2], {28'h0, hien, 3'b000}, r);
      bus(1'b1, ad[4], {31'h0, sram}, r);
      bus(1'b1, ad[0], {16'h0, pg1}, r);
      bus(1'b1, ad[1], {16'h0, pg2}, r);
      bus(1'b0, ad[3], 32'h0, r);
      chk("ctrl_reg", r, {16'h0, ctrl});
      bus(1'b0, ad[2], 32'h0, r);
      chk("upper_reg", r, {28'h0, hien, 3'b000});
      bus(1'b0, ad[0], 32'h0, r);
      chk("page1_reg", r, {16'h0, pg1});
      bus(1'b0, ad[4], 32'h0, r);
      chk("mode_reg", r, {31'h0, sram});
      bus(1'b0, ad[5], 32'h0, r);
      chk("unmapped", r, 32'h0);
      for (k = 0; k < 4; k++) acc(k);
    end
    end_of_test;
  end
endmodule // emw_ctrl_bench
